// file: design/fcsd_host.sv
// Host-side controller that issues flash command sequences over the asynchronous bus
`timescale 1ns/1ns
`include "fcsd_map.svh"
module fcsd_host (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [31:0] reg_rdata,
	// Flash bus
	output logic [20:0] flash_addr,
	output logic [15:0] flash_dq_out,
	output logic flash_dq_oe,
	input wire logic [15:0] flash_dq_in,
	output logic flash_ce_n,
	output logic flash_we_n,
	output logic flash_oe_n,
	output logic flash_reset_n,
	input wire logic ready_busy_n_output
);
	import fcsd_pkg::*;

	// ----------------------------------------
	// Reset release and input synchronisers
	// ----------------------------------------
	logic [1:0] rst_sync_ff;
	logic rst_n;
	logic [15:0] dq_meta_ff, dq_sync_ff;
	logic rb_meta_ff, rb_sync_ff;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_sync_ff <= 2'h0;
		end else begin
			rst_sync_ff <= {rst_sync_ff[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_ff[1];

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dq_meta_ff <= 16'h0000;
			dq_sync_ff <= 16'h0000;
			rb_meta_ff <= 1'b1;
			rb_sync_ff <= 1'b1;
		end else begin
			dq_meta_ff <= flash_dq_in;
			dq_sync_ff <= dq_meta_ff;
			rb_meta_ff <= ready_busy_n_output;
			rb_sync_ff <= rb_meta_ff;
		end
	end

	// ----------------------------------------
	// Command registers
	// ----------------------------------------
	fcsd_cmd_e cmd_ff;
	logic byte_mode_ff, poll_en_ff;
	logic [20:0] addr_ff;
	logic [15:0] wdata_ff;
	logic [15:0] rdata_ff;
	logic busy_ff, err_ff, polling_ff, prev_tog_ff, tmo_seen_ff;
	logic start;
	fcsd_state_e state_ff;
	logic [2:0] step_ff;
	logic [3:0] cnt_ff;
	fcsd_step_s cur;
	logic seq_done;
	fcsd_step_s ahead;

	// A command written while busy is dropped so a sequence is never split
	assign start = reg_write && reg_addr == `FCSD_REG_CTRL && !busy_ff;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cmd_ff <= FCSD_READ;
			byte_mode_ff <= 1'b0;
			poll_en_ff <= 1'b0;
			addr_ff <= 21'h000000;
			wdata_ff <= 16'h0000;
		end else if (reg_write && !busy_ff) begin
			unique case (reg_addr)
				`FCSD_REG_CTRL: begin
					cmd_ff <= fcsd_cmd_e'(reg_wdata[`FCSD_CTRL_CMD_MSB:`FCSD_CTRL_CMD_LSB]);
					byte_mode_ff <= reg_wdata[`FCSD_CTRL_BYTE_MODE];
					poll_en_ff <= reg_wdata[`FCSD_CTRL_POLL_EN];
				end
				`FCSD_REG_ADDR: addr_ff <= reg_wdata[20:0];
				`FCSD_REG_WDATA: wdata_ff <= reg_wdata[15:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 32'h00000000;
		end else if (reg_read) begin
			unique case (reg_addr)
				`FCSD_REG_CTRL: reg_rdata <= {26'h0000000, poll_en_ff, byte_mode_ff, cmd_ff};
				`FCSD_REG_ADDR: reg_rdata <= {11'h000, addr_ff};
				`FCSD_REG_WDATA: reg_rdata <= {16'h0000, wdata_ff};
				`FCSD_REG_STATUS: reg_rdata <= {rdata_ff, 13'h0000, rb_sync_ff, err_ff, busy_ff};
				default: reg_rdata <= 32'h00000000;
			endcase
		end
	end

	// ----------------------------------------
	// Sequence table
	// ----------------------------------------
	function automatic fcsd_step_s step_of(fcsd_cmd_e c, logic [2:0] n, logic bm,
			logic [20:0] a, logic [15:0] v);
		logic [20:0] u1, u2, bk;
		fcsd_step_s s;
		u1 = bm ? `FCSD_UNLOCK1_BYTE : `FCSD_UNLOCK1_WORD;
		u2 = bm ? `FCSD_UNLOCK2_BYTE : `FCSD_UNLOCK2_WORD;
		bk = {a[20:11], u1[10:0]};
		s = '{valid: 1'b0, rd: 1'b0, a: a, d: 16'h0000};
		unique case (c)
			FCSD_READ: if (n == 3'h0) s = '{1'b1, 1'b1, a, 16'h0000};
			FCSD_RESET: if (n == 3'h0) s = '{1'b1, 1'b0, a, `FCSD_D_RESET};
			FCSD_SUSPEND: if (n == 3'h0) s = '{1'b1, 1'b0, a, `FCSD_D_SUSPEND};
			FCSD_RESUME: if (n == 3'h0) s = '{1'b1, 1'b0, a, `FCSD_D_RESUME};
			FCSD_QUERY: if (n == 3'h0) begin
				s = '{1'b1, 1'b0, bm ? `FCSD_QUERY_BYTE : `FCSD_QUERY_WORD, `FCSD_D_QUERY};
			end
			FCSD_BYPASS_PROG: begin
				if (n == 3'h0) s = '{1'b1, 1'b0, a, `FCSD_D_PROGRAM};
				else if (n == 3'h1) s = '{1'b1, 1'b0, a, v};
			end
			FCSD_BYPASS_EXIT: begin
				if (n == 3'h0) s = '{1'b1, 1'b0, a, `FCSD_D_AUTOSEL};
				else if (n == 3'h1) s = '{1'b1, 1'b0, a, `FCSD_D_BYPASS_EXIT};
			end
			default: begin
				// Unlocked sequences share cycles 0/1, erase repeats them at 3/4
				if (n == 3'h0 || n == 3'h3) s = '{1'b1, 1'b0, u1, `FCSD_D_UNLOCK1};
				else if (n == 3'h1 || n == 3'h4) s = '{1'b1, 1'b0, u2, `FCSD_D_UNLOCK2};
				else if (n == 3'h2) begin
					unique case (c)
						FCSD_AUTOSEL: s = '{1'b1, 1'b0, bk, `FCSD_D_AUTOSEL};
						FCSD_PROGRAM: s = '{1'b1, 1'b0, u1, `FCSD_D_PROGRAM};
						FCSD_BYPASS: s = '{1'b1, 1'b0, u1, `FCSD_D_BYPASS};
						FCSD_TEMP_UNPROT: s = '{1'b1, 1'b0, u1, `FCSD_D_TEMP_UNPROT};
						default: s = '{1'b1, 1'b0, u1, `FCSD_D_ERASE_SETUP};
					endcase
				end
				// Unlock cycles 3/4 only exist for erase
				if ((n == 3'h3 || n == 3'h4) && c != FCSD_CHIP_ERASE && c != FCSD_SECTOR_ERASE) begin
					s.valid = 1'b0;
				end
				if (n == 3'h3 && c == FCSD_AUTOSEL) s = '{1'b1, 1'b1, a, 16'h0000};
				if (n == 3'h3 && c == FCSD_PROGRAM) s = '{1'b1, 1'b0, a, v};
				if (n == 3'h5 && c == FCSD_CHIP_ERASE) s = '{1'b1, 1'b0, u1, `FCSD_D_CHIP_ERASE};
				if (n == 3'h5 && c == FCSD_SECTOR_ERASE) begin
					s = '{1'b1, 1'b0, {a[20:12], 12'h000}, `FCSD_D_SECTOR_ERASE};
				end
			end
		endcase
		return s;
	endfunction

	// Polling re-reads the target address until the toggle bit settles or still toggles on the read after a timeout
	assign cur = polling_ff ? '{1'b1, 1'b1, addr_ff, 16'h0000} :
		step_of(cmd_ff, step_ff, byte_mode_ff, addr_ff, wdata_ff);
	assign ahead = step_of(cmd_ff, step_ff + 3'h1, byte_mode_ff, addr_ff, wdata_ff);
	assign seq_done = !ahead.valid;

	// ----------------------------------------
	// Bus cycle engine
	// ----------------------------------------
	logic busy_op;
	assign busy_op = cmd_ff == FCSD_PROGRAM || cmd_ff == FCSD_BYPASS_PROG ||
		cmd_ff == FCSD_CHIP_ERASE || cmd_ff == FCSD_SECTOR_ERASE;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= FCSD_IDLE;
			step_ff <= 3'h0;
			cnt_ff <= 4'h0;
			busy_ff <= 1'b0;
			polling_ff <= 1'b0;
			err_ff <= 1'b0;
			rdata_ff <= 16'h0000;
			prev_tog_ff <= 1'b0;
			tmo_seen_ff <= 1'b0;
		end else begin
			unique case (state_ff)
				FCSD_IDLE: if (start) begin
					state_ff <= FCSD_SETUP;
					step_ff <= 3'h0;
					busy_ff <= 1'b1;
					err_ff <= 1'b0;
				end
				FCSD_SETUP: begin
					state_ff <= FCSD_STROBE;
					// One extra count: the strobe falls a cycle after select
					cnt_ff <= cur.rd ? 4'(`FCSD_STROBE_CYC + `FCSD_SYNC_CYC + 1) :
						4'(`FCSD_STROBE_CYC + 1);
				end
				FCSD_STROBE: if (cnt_ff == 4'h1) begin
					state_ff <= FCSD_HOLD;
					if (cur.rd) rdata_ff <= dq_sync_ff;
				end else begin
					cnt_ff <= cnt_ff - 4'h1;
				end
				FCSD_HOLD: begin
					if (polling_ff) begin
						// Timeout only counts if the read after it still toggles
						if (step_ff != 3'h0 && (tmo_seen_ff ||
								rdata_ff[`FCSD_BIT_TOGGLE] == prev_tog_ff)) begin
							err_ff <= rdata_ff[`FCSD_BIT_TOGGLE] != prev_tog_ff;
							polling_ff <= 1'b0;
							state_ff <= FCSD_IDLE;
							busy_ff <= 1'b0;
						end else begin
							step_ff <= 3'h1;
							state_ff <= FCSD_SETUP;
						end
						tmo_seen_ff <= step_ff != 3'h0 && rdata_ff[`FCSD_BIT_TIMEOUT];
						prev_tog_ff <= rdata_ff[`FCSD_BIT_TOGGLE];
					end else if (seq_done) begin
						if (poll_en_ff && busy_op) begin
							polling_ff <= 1'b1;
							tmo_seen_ff <= 1'b0;
							step_ff <= 3'h0;
							state_ff <= FCSD_SETUP;
						end else begin
							state_ff <= FCSD_IDLE;
							busy_ff <= 1'b0;
						end
					end else begin
						step_ff <= step_ff + 3'h1;
						state_ff <= FCSD_SETUP;
					end
				end
			endcase
		end
	end

	// ----------------------------------------
	// Flash pins
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			flash_addr <= 21'h000000;
			flash_dq_out <= 16'h0000;
			flash_dq_oe <= 1'b0;
			flash_ce_n <= 1'b1;
			flash_we_n <= 1'b1;
			flash_oe_n <= 1'b1;
			flash_reset_n <= 1'b0;
		end else begin
			flash_reset_n <= 1'b1;
			unique case (state_ff)
				FCSD_IDLE: ;
				FCSD_SETUP: begin
					flash_addr <= cur.a;
					flash_dq_out <= cur.d;
					flash_dq_oe <= !cur.rd;
					flash_ce_n <= 1'b0;
				end
				FCSD_STROBE: begin
					flash_we_n <= cur.rd || cnt_ff == 4'h1;
					flash_oe_n <= !cur.rd || cnt_ff == 4'h1;
					flash_ce_n <= cnt_ff == 4'h1;
				end
				FCSD_HOLD: flash_dq_oe <= 1'b0;
			endcase
		end
	end
endmodule // fcsd_host

// file: design/fcsd_map.svh
// Offsets, command codes, unlock addresses and timing counts of the flash command sequencer
`ifndef FCSD_MAP_SVH
`define FCSD_MAP_SVH
// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define FCSD_REG_CTRL 8'h00
`define FCSD_REG_ADDR 8'h04
`define FCSD_REG_WDATA 8'h08
`define FCSD_REG_STATUS 8'h0c
// ----------------------------------------
// Control field positions
// ----------------------------------------
`define FCSD_CTRL_CMD_LSB 0
`define FCSD_CTRL_CMD_MSB 3
`define FCSD_CTRL_BYTE_MODE 4
`define FCSD_CTRL_POLL_EN 5
`define FCSD_CTRL_RESET 8'h00
// ----------------------------------------
// Unlock addresses and command data
// ----------------------------------------
`define FCSD_UNLOCK1_WORD 21'h000555
`define FCSD_UNLOCK2_WORD 21'h0002aa
`define FCSD_UNLOCK1_BYTE 21'h000aaa
`define FCSD_UNLOCK2_BYTE 21'h000555
`define FCSD_QUERY_WORD 21'h000055
`define FCSD_QUERY_BYTE 21'h0000aa
`define FCSD_D_UNLOCK1 16'h00aa
`define FCSD_D_UNLOCK2 16'h0055
`define FCSD_D_RESET 16'h00f0
`define FCSD_D_AUTOSEL 16'h0090
`define FCSD_D_PROGRAM 16'h00a0
`define FCSD_D_BYPASS 16'h0020
`define FCSD_D_BYPASS_EXIT 16'h0000
`define FCSD_D_ERASE_SETUP 16'h0080
`define FCSD_D_CHIP_ERASE 16'h0010
`define FCSD_D_SECTOR_ERASE 16'h0030
`define FCSD_D_SUSPEND 16'h00b0
`define FCSD_D_RESUME 16'h0030
`define FCSD_D_QUERY 16'h0098
`define FCSD_D_TEMP_UNPROT 16'h0077
// ----------------------------------------
// Status bit positions on the data bus
// ----------------------------------------
`define FCSD_BIT_TOGGLE 6
`define FCSD_BIT_TIMEOUT 5
// ----------------------------------------
// Timing
// ----------------------------------------
`define FCSD_CLK_NS 20
`define FCSD_T_STROBE_NS 70
`define FCSD_STROBE_CYC ((`FCSD_T_STROBE_NS + `FCSD_CLK_NS - 1) / `FCSD_CLK_NS)
`define FCSD_SYNC_CYC 2
`endif

// file: design/fcsd_pkg.sv
// Types of the flash command sequencer
package fcsd_pkg;
	typedef enum logic [3:0] {
		FCSD_READ, FCSD_RESET, FCSD_AUTOSEL, FCSD_PROGRAM, FCSD_BYPASS,
		FCSD_BYPASS_PROG, FCSD_BYPASS_EXIT, FCSD_CHIP_ERASE, FCSD_SECTOR_ERASE,
		FCSD_SUSPEND, FCSD_RESUME, FCSD_QUERY, FCSD_TEMP_UNPROT
	} fcsd_cmd_e;
	typedef enum {FCSD_IDLE, FCSD_SETUP, FCSD_STROBE, FCSD_HOLD} fcsd_state_e;
	typedef struct packed {
		logic valid;
		logic rd;
		logic [20:0] a;
		logic [15:0] d;
	} fcsd_step_s;
endpackage

// file: tb/fcsd_flash_model.sv
// Behavioural flash device answering the host's bus cycles
`timescale 1ns/1ns
module fcsd_flash_model (
	// Flash bus
	input wire logic [20:0] flash_addr,
	input wire logic [15:0] flash_dq_out,
	input wire logic flash_ce_n,
	input wire logic flash_we_n,
	input wire logic flash_oe_n,
	input wire logic flash_reset_n,
	output logic [15:0] flash_dq_in,
	output logic ready_busy_n_output
);
	logic [20:0] log_a[$];
	logic [15:0] log_d[$];
	logic [20:0] lat_a;
	logic [15:0] last_q = 16'h0000;
	logic busy = 1'b0;
	logic tog = 1'b0;
	logic autosel = 1'b0;
	int unl = 0;
	event go;
	wire wr = !flash_ce_n && !flash_we_n;
	wire rd = !flash_ce_n && !flash_oe_n;
	always @(posedge wr) lat_a = flash_addr;
	always @(negedge wr) begin
		log_a.push_back(lat_a);
		log_d.push_back(flash_dq_out);
		// Program data matched first so a data word never acts as a command
		if (unl == 3 || (unl == 2 && flash_dq_out[7:0] inside {8'h10, 8'h30})) begin
			unl = 0;
			->go;
		end else if (flash_dq_out[7:0] == 8'hf0) begin
			autosel = 1'b0;
			unl = 0;
		end else if (unl == 0 && flash_dq_out[7:0] == 8'haa) unl = 1;
		else if (unl == 1 && flash_dq_out[7:0] == 8'h55) unl = 2;
		else if (unl == 2 && flash_dq_out[7:0] == 8'h90) begin
			autosel = 1'b1;
			unl = 0;
		end else if (unl != 1 && flash_dq_out[7:0] == 8'ha0) unl = 3;
		else unl = 0;
	end
	// Slow answer: busy long enough for the host to poll through it
	always @(go) begin
		busy = 1'b1;
		#400;
		busy = 1'b0;
	end
	always @(negedge flash_reset_n) autosel = 1'b0;
	always @(posedge rd) if (busy) tog = ~tog;
	// Released bus shows the inverse of the last value, never a stale copy
	always @(rd, flash_addr, busy, tog, autosel) begin
		if (rd)
			last_q = busy ? {9'h000, tog, 6'h00} :
				autosel ? 16'h0001 : flash_addr[15:0] ^ 16'h5a5a;
		flash_dq_in = rd ? last_q : ~last_q;
	end
	assign ready_busy_n_output = !busy;
endmodule // fcsd_flash_model

// file: tb/fcsd_host_monitor.sv
// Bus-cycle checker of the flash command sequencer host
`timescale 1ns/1ns
module fcsd_host_monitor (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Flash bus
	input wire logic [20:0] flash_addr,
	input wire logic [15:0] flash_dq_out,
	input wire logic flash_dq_oe,
	input wire logic flash_ce_n,
	input wire logic flash_we_n,
	input wire logic flash_oe_n
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	wr_rd_excl_a: assert property (!(!flash_we_n && !flash_oe_n))
		else $error("write and read strobes overlap");
	we_qualified_a: assert property (!flash_we_n |-> !flash_ce_n && flash_dq_oe)
		else $error("write strobe without select or drive");
	read_released_a: assert property (!flash_oe_n |-> !flash_dq_oe)
		else $error("data driven during a read");
	strobe_width_a: assert property ($fell(flash_we_n) |-> !flash_we_n [*4])
		else $error("write strobe too short");
	addr_hold_a: assert property (!flash_we_n && $past(!flash_we_n) |-> $stable(flash_addr))
		else $error("address moved inside strobe");
	data_hold_a: assert property (!flash_we_n && $past(!flash_we_n) |-> $stable(flash_dq_out))
		else $error("data moved inside strobe");
	second_unlock_a: assert property ($fell(flash_we_n) && flash_dq_out[7:0] == 8'h55 |->
		flash_addr[10:0] == 11'h2aa || flash_addr[10:0] == 11'h555)
		else $error("second unlock at wrong offset");
	upper_zero_a: assert property ($fell(flash_we_n) && flash_dq_out[7:0] == 8'haa |->
		flash_dq_out[15:8] == 8'h00)
		else $error("upper byte set in command cycle");
	cover property ($fell(flash_we_n));
	cover property ($fell(flash_oe_n));
	cover property ($fell(flash_we_n) && flash_dq_out[7:0] == 8'h30);
endmodule // fcsd_host_monitor

bind fcsd_host fcsd_host_monitor mon (.clk(clk), .reset_n(reset_n), .flash_addr(flash_addr),
	.flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe), .flash_ce_n(flash_ce_n),
	.flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n));

// file: tb/fcsd_host_tb_top.sv
// Self-checking testbench of the flash command sequencer host
`timescale 1ns/1ns
module fcsd_host_tb_top;
	import fcsd_pkg::*;
	logic clk, reset_n, reg_write, reg_read, flash_dq_oe, flash_ce_n, flash_we_n;
	logic flash_oe_n, flash_reset_n, ready_busy_n_output;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, seed;
	logic [20:0] flash_addr;
	logic [15:0] flash_dq_out, flash_dq_in;
	logic [20:0] ea[$], em[$];
	logic [15:0] ed[$], edm[$];
	int miscompares, cmp_count;
	logic id_mode;
	fcsd_host uut (.clk, .reset_n, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
		.flash_addr, .flash_dq_out, .flash_dq_oe, .flash_dq_in, .flash_ce_n, .flash_we_n,
		.flash_oe_n, .flash_reset_n, .ready_busy_n_output);
	fcsd_flash_model dev (.flash_addr, .flash_dq_out, .flash_ce_n, .flash_we_n, .flash_oe_n,
		.flash_reset_n, .flash_dq_in, .ready_busy_n_output);
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	function automatic void xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
	endfunction
	// Array contents the partner model holds at each location
	function automatic logic [15:0] arr(logic [20:0] a);
		return a[15:0] ^ 16'h5a5a;
	endfunction
	function automatic void push(logic [20:0] a, logic [20:0] m, logic [15:0] d, logic [15:0] dm);
		ea.push_back(a);
		em.push_back(m);
		ed.push_back(d);
		edm.push_back(dm);
	endfunction
	function automatic void plan(fcsd_cmd_e c, logic bm, logic [20:0] a, logic [15:0] d);
		logic [20:0] u1, u2, lo;
		u1 = bm ? 21'h000aaa : 21'h000555;
		u2 = bm ? 21'h000555 : 21'h0002aa;
		lo = 21'h0007ff;
		if (c inside {FCSD_AUTOSEL, FCSD_PROGRAM, FCSD_BYPASS, FCSD_CHIP_ERASE, FCSD_SECTOR_ERASE,
			FCSD_TEMP_UNPROT}) begin
			push(u1, lo, 16'h00aa, 16'h00ff);
			push(u2, lo, 16'h0055, 16'h00ff);
		end
		case (c)
			FCSD_RESET: push(0, 0, 16'h00f0, 16'h00ff);
			FCSD_AUTOSEL: push(u1, lo, 16'h0090, 16'h00ff);
			FCSD_PROGRAM: push(u1, lo, 16'h00a0, 16'h00ff);
			FCSD_BYPASS: push(u1, lo, 16'h0020, 16'h00ff);
			FCSD_BYPASS_PROG: push(0, 0, 16'h00a0, 16'h00ff);
			FCSD_BYPASS_EXIT: push(0, 0, 16'h0090, 16'h00ff);
			FCSD_CHIP_ERASE, FCSD_SECTOR_ERASE: begin
				push(u1, lo, 16'h0080, 16'h00ff);
				push(u1, lo, 16'h00aa, 16'h00ff);
				push(u2, lo, 16'h0055, 16'h00ff);
			end
			FCSD_SUSPEND: push(0, 0, 16'h00b0, 16'h00ff);
			FCSD_RESUME: push(0, 0, 16'h0030, 16'h00ff);
			FCSD_QUERY: push(bm ? 21'h0000aa : 21'h000055, lo, 16'h0098, 16'h00ff);
			FCSD_TEMP_UNPROT: push(u1, lo, 16'h0077, 16'h00ff);
			default: ;
		endcase
		if (c inside {FCSD_PROGRAM, FCSD_BYPASS_PROG}) push(a, 21'h1fffff, d, 16'hffff);
		if (c == FCSD_BYPASS_EXIT) push(0, 0, 16'h0000, 16'h00ff);
		if (c == FCSD_CHIP_ERASE) push(u1, lo, 16'h0010, 16'h00ff);
		if (c == FCSD_SECTOR_ERASE) push(a, 21'h1ff000, 16'h0030, 16'h00ff);
	endfunction
	// Strobe left high between calls so back-to-back writes need no gap
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clk);
		reg_read <= 1'b0;
		#1 chk(reg_rdata & m, e);
		@(posedge clk);
	endtask
	task automatic run(input fcsd_cmd_e c, input logic bm, input logic pe);
		logic [20:0] a;
		logic [15:0] d, exp_rd;
		logic [31:0] m;
		int n, k;
		xs();
		a = seed[20:0];
		d = {seed[31:24], 2'b11, seed[29:24]};
		dev.log_a.delete();
		dev.log_d.delete();
		plan(c, bm, a, d);
		wr(8'h04, {11'h000, a});
		wr(8'h08, {16'h0000, d});
		wr(8'h00, {26'h0000000, pe, bm, c});
		reg_write <= 1'b0;
		k = 0;
		for (n = 0; n < 3000 && (k < 8 || dev.log_a.size() < ea.size()); n++) begin
			@(posedge clk);
			k = (flash_ce_n && ready_busy_n_output) ? k + 1 : 0;
		end
		if (n == 3000) begin
			miscompares++;
			end_sim();
		end
		chk(dev.log_a.size(), ea.size());
		for (n = 0; n < ea.size() && n < dev.log_a.size(); n++) begin
			chk((dev.log_a[n] ^ ea[n]) & em[n], 0);
			chk(dev.log_d[n] & edm[n], ed[n]);
		end
		ea.delete();
		em.delete();
		ed.delete();
		edm.delete();
		// Idle, no error, ready seen; read data only where a read was issued
		exp_rd = (c == FCSD_AUTOSEL || id_mode) ? 16'h0001 : arr(a);
		m = (c inside {FCSD_READ, FCSD_AUTOSEL}) ? 32'hffff0007 : 32'h00000007;
		rd(8'h0c, {exp_rd, 16'h0004} & m, m);
		if (c == FCSD_AUTOSEL) id_mode = 1'b1;
		else if (c == FCSD_RESET) id_mode = 1'b0;
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial begin
		reset_n = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 32'h00000000;
		reg_write = 1'b0;
		reg_read = 1'b0;
		seed = 32'h4a8f;
		miscompares = 0;
		cmp_count = 0;
		id_mode = 1'b0;
		repeat (12) @(posedge clk);
		reset_n <= 1'b1;
		repeat (3) @(posedge clk);
		rd(8'h00, 32'h00000000, 32'hffffffff);
		rd(8'h10, 32'h00000000, 32'hffffffff);
		for (int i = 0; i < 26; i++) run(fcsd_cmd_e'(4'(i % 13)), i >= 13, i >= 13);
		// Corner: identification readout between suspend and resume
		run(FCSD_SECTOR_ERASE, 1'b0, 1'b1);
		run(FCSD_SUSPEND, 1'b0, 1'b0);
		run(FCSD_AUTOSEL, 1'b0, 1'b0);
		run(FCSD_RESUME, 1'b0, 1'b0);
		run(FCSD_RESET, 1'b0, 1'b0);
		for (int i = 0; i < 6; i++) run(fcsd_cmd_e'(4'(seed % 13)), seed[9], seed[10]);
		end_sim();
	end
endmodule // fcsd_host_tb_top
